// File: pwm_out_defines.vh
// Register offsets, field positions and reset values of the output stage.
`ifndef PWM_OUT_DEFINES_VH
`define PWM_OUT_DEFINES_VH

`define OFS_SYNC_UPDATE     12'h000
`define OFS_OUT_ENABLE      12'h008
`define OFS_POLARITY        12'h00C
`define OFS_FAULT_ACTION    12'h010
`define OFS_INT_ENABLE      12'h014
`define OFS_RAW_STATUS      12'h018
`define OFS_MASKED_CLEAR    12'h01C
`define OFS_FAULT_LEVEL     12'h020
`define OFS_GEN_CONTROL     12'h040
`define OFS_GEN_LOAD        12'h050
`define OFS_GEN_COUNT       12'h054
`define OFS_GEN_CMP_A       12'h058
`define OFS_GEN_CMP_B       12'h05C

`define BIT_CHAN_A          0
`define BIT_CHAN_B          1
`define BIT_GEN_IRQ         0
`define BIT_FAULT_IRQ       16
`define BIT_SYNC_REQ        0
`define BIT_FAULT_LEVEL     0
`define BIT_ENABLE          0
`define BIT_UPDOWN          1
`define BIT_DEBUG_RUN       2
`define BIT_LOAD_UPD        3
`define BIT_CMP_A_UPD       4
`define BIT_CMP_B_UPD       5

`define RST_CTRL            6'h00
`define RST_PAIR            2'h0
`define RST_WORD            32'h00000000
`define RST_COUNT           16'h0000

`endif

// File: pwm_sync2.v
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module pwm_sync2 (
    input wire clk,
    input wire rst_n,
    input wire async_in,
    output reg sync_out
);
    reg meta_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pwm_sync2
`default_nettype wire

// File: pwm_out_stage.v
// One channel of the output stage: enable, fault forcing and inversion.
`timescale 1ns/10ps
`default_nettype none
module pwm_out_stage (
    input wire clk,
    input wire rst_n,
    input wire gen_in,
    input wire out_en,
    input wire force_low,
    input wire fault,
    input wire invert,
    output reg pin_r
);
    wire gated;
    wire forced;

    // A disabled channel still passes a zero through the inverter.
    assign gated = out_en & gen_in;
    // Forcing sits ahead of the inverter, so a forced inverted pin is High.
    assign forced = gated & ~(fault & force_low);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= forced ^ invert;
        end
    end
endmodule // pwm_out_stage
`default_nettype wire

// File: pwm_output_fault_and_gen_control.v
// Output stage, module interrupts and generator zero of the PWM block.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_out_defines.vh"
module pwm_output_fault_and_gen_control #(
    parameter CNT_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire fault_in,
    input wire debug_in,
    input wire gen_irq_in,
    output wire channel_a_out,
    output wire channel_b_out,
    output reg module_irq
);
    // Register state.
    reg sync_req_r;
    reg [1:0] output_pin_enable_r;
    reg [1:0] output_polarity_control_r;
    reg [1:0] fault_output_action_r;
    reg gen_irq_en_r;
    reg fault_irq_en_r;
    reg fault_latch_r;
    reg [5:0] generator_zero_control_r;
    reg [CNT_W-1:0] load_wr_r;
    reg [CNT_W-1:0] cmp_a_wr_r;
    reg [CNT_W-1:0] cmp_b_wr_r;
    reg [CNT_W-1:0] load_act_r;
    reg [CNT_W-1:0] cmp_a_act_r;
    reg [CNT_W-1:0] cmp_b_act_r;
    reg [CNT_W-1:0] count_r;
    reg dir_up_nxt;
    reg dir_up_r;
    reg gen_a_r;
    reg gen_b_r;
    reg [CNT_W-1:0] count_nxt;

    wire fault_s;
    wire debug_s;
    wire fault_cond;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire gen_on;
    wire halted;
    wire at_zero;
    wire apply_sync;
    wire apply_load;
    wire apply_cmp_a;
    wire apply_cmp_b;
    wire [CNT_W-1:0] load_use;
    wire [CNT_W-1:0] cmp_a_use;
    wire [CNT_W-1:0] cmp_b_use;
    wire [31:0] raw_word;
    wire [31:0] masked_word;
    reg [31:0] rd_word;

    // Both inputs come from pins, so each passes two flip-flops first.
    pwm_sync2 u_sync_fault (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(fault_in),
        .sync_out(fault_s)
    );

    pwm_sync2 u_sync_debug (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(debug_in),
        .sync_out(debug_s)
    );

    assign fault_cond = fault_s | debug_s;

    // The bus answers one cycle into the access phase; the write lands then.
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;

    // Interrupt status words.
    assign raw_word = ({31'h00000000, gen_irq_in} << `BIT_GEN_IRQ) |
        ({31'h00000000, fault_latch_r} << `BIT_FAULT_IRQ);
    assign masked_word =
        ({31'h00000000, gen_irq_in & gen_irq_en_r} << `BIT_GEN_IRQ) |
        ({31'h00000000, fault_latch_r & fault_irq_en_r}
        << `BIT_FAULT_IRQ);

    // Address decode and read mux; reserved bits read as zero.
    reg addr_hit;
    always @* begin
        rd_word = `RST_WORD;
        addr_hit = 1'b1;
        case (paddr)
            `OFS_SYNC_UPDATE: begin
                rd_word[`BIT_SYNC_REQ] = sync_req_r;
            end
            `OFS_OUT_ENABLE: begin
                rd_word[1:0] = output_pin_enable_r;
            end
            `OFS_POLARITY: begin
                rd_word[1:0] = output_polarity_control_r;
            end
            `OFS_FAULT_ACTION: begin
                rd_word[1:0] = fault_output_action_r;
            end
            `OFS_INT_ENABLE: begin
                rd_word[`BIT_GEN_IRQ] = gen_irq_en_r;
                rd_word[`BIT_FAULT_IRQ] = fault_irq_en_r;
            end
            `OFS_RAW_STATUS: begin
                rd_word = raw_word;
            end
            `OFS_MASKED_CLEAR: begin
                rd_word = masked_word;
            end
            `OFS_FAULT_LEVEL: begin
                rd_word[`BIT_FAULT_LEVEL] = fault_s;
            end
            `OFS_GEN_CONTROL: begin
                rd_word[5:0] = generator_zero_control_r;
            end
            `OFS_GEN_LOAD: begin
                rd_word[CNT_W-1:0] = load_wr_r;
            end
            `OFS_GEN_COUNT: begin
                rd_word[CNT_W-1:0] = count_r;
            end
            `OFS_GEN_CMP_A: begin
                rd_word[CNT_W-1:0] = cmp_a_wr_r;
            end
            `OFS_GEN_CMP_B: begin
                rd_word[CNT_W-1:0] = cmp_b_wr_r;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end
    assign addr_ok = addr_hit;

    // APB answer: pready, prdata and pslverr all come from flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `RST_WORD;
            pslverr <= 1'b0;
        end else begin
            if (psel & penable & ~pready) begin
                pready <= 1'b1;
                pslverr <= ~addr_ok;
                if (rd_en) begin
                    prdata <= rd_word;
                end
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Plain control registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_pin_enable_r <= `RST_PAIR;
            output_polarity_control_r <= `RST_PAIR;
            fault_output_action_r <= `RST_PAIR;
            gen_irq_en_r <= 1'b0;
            fault_irq_en_r <= 1'b0;
            generator_zero_control_r <= `RST_CTRL;
            load_wr_r <= `RST_COUNT;
            cmp_a_wr_r <= `RST_COUNT;
            cmp_b_wr_r <= `RST_COUNT;
        end else if (wr_en) begin
            case (paddr)
                `OFS_OUT_ENABLE: begin
                    output_pin_enable_r <= pwdata[1:0];
                end
                `OFS_POLARITY: begin
                    output_polarity_control_r <= pwdata[1:0];
                end
                `OFS_FAULT_ACTION: begin
                    fault_output_action_r <= pwdata[1:0];
                end
                `OFS_INT_ENABLE: begin
                    gen_irq_en_r <= pwdata[`BIT_GEN_IRQ];
                    fault_irq_en_r <= pwdata[`BIT_FAULT_IRQ];
                end
                `OFS_GEN_CONTROL: begin
                    generator_zero_control_r <= pwdata[5:0];
                end
                `OFS_GEN_LOAD: begin
                    load_wr_r <= pwdata[CNT_W-1:0];
                end
                `OFS_GEN_CMP_A: begin
                    cmp_a_wr_r <= pwdata[CNT_W-1:0];
                end
                `OFS_GEN_CMP_B: begin
                    cmp_b_wr_r <= pwdata[CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Fault latch: a fault level seen in the clearing cycle keeps it set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_latch_r <= 1'b0;
        end else if (fault_s) begin
            fault_latch_r <= 1'b1;
        end else if (wr_en && paddr == `OFS_MASKED_CLEAR &&
                     pwdata[`BIT_FAULT_IRQ]) begin
            fault_latch_r <= 1'b0;
        end
    end

    // Generator control decode.
    assign gen_on = generator_zero_control_r[`BIT_ENABLE];
    // Without run-through, the counter parks at zero until debug ends.
    assign halted = debug_s & ~generator_zero_control_r[`BIT_DEBUG_RUN] &
        (count_r == `RST_COUNT);
    assign at_zero = gen_on & (count_r == `RST_COUNT);
    assign apply_sync = at_zero & sync_req_r;
    assign apply_load = at_zero & (~generator_zero_control_r[`BIT_LOAD_UPD] |
        sync_req_r);
    assign apply_cmp_a = at_zero &
        (~generator_zero_control_r[`BIT_CMP_A_UPD] | sync_req_r);
    assign apply_cmp_b = at_zero &
        (~generator_zero_control_r[`BIT_CMP_B_UPD] | sync_req_r);
    assign load_use = apply_load ? load_wr_r : load_act_r;
    assign cmp_a_use = apply_cmp_a ? cmp_a_wr_r : cmp_a_act_r;
    assign cmp_b_use = apply_cmp_b ? cmp_b_wr_r : cmp_b_act_r;

    // Sync request: software sets it, only the zero point clears it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_req_r <= 1'b0;
        end else if (wr_en && paddr == `OFS_SYNC_UPDATE &&
                     pwdata[`BIT_SYNC_REQ]) begin
            sync_req_r <= 1'b1;
        end else if (apply_sync) begin
            sync_req_r <= 1'b0;
        end
    end

    // Active load and comparator values change only at counter zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_act_r <= `RST_COUNT;
            cmp_a_act_r <= `RST_COUNT;
            cmp_b_act_r <= `RST_COUNT;
        end else begin
            load_act_r <= load_use;
            cmp_a_act_r <= cmp_a_use;
            cmp_b_act_r <= cmp_b_use;
        end
    end

    // Next counter value for both counting patterns.
    always @* begin
        count_nxt = count_r;
        dir_up_nxt = dir_up_r;
        if (!generator_zero_control_r[`BIT_UPDOWN]) begin
            dir_up_nxt = 1'b0;
            if (count_r == `RST_COUNT) begin
                count_nxt = load_use;
            end else begin
                count_nxt = count_r - 1'b1;
            end
        end else begin
            if (count_r == `RST_COUNT) begin
                dir_up_nxt = (load_use != `RST_COUNT);
                if (load_use != `RST_COUNT) begin
                    count_nxt = count_r + 1'b1;
                end
            end else if (dir_up_r && count_r < load_use) begin
                count_nxt = count_r + 1'b1;
            end else begin
                dir_up_nxt = 1'b0;
                count_nxt = count_r - 1'b1;
            end
        end
    end

    // One counter drives both channels.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= `RST_COUNT;
            dir_up_r <= 1'b0;
            gen_a_r <= 1'b0;
            gen_b_r <= 1'b0;
        end else if (!gen_on) begin
            // A disabled generator holds its count and drives nothing.
            gen_a_r <= 1'b0;
            gen_b_r <= 1'b0;
        end else if (!halted) begin
            count_r <= count_nxt;
            dir_up_r <= dir_up_nxt;
            gen_a_r <= (count_nxt < cmp_a_use);
            gen_b_r <= (count_nxt < cmp_b_use);
        end
    end

    // Channel output stages.
    pwm_out_stage u_stage_a (
        .clk(pclk),
        .rst_n(presetn),
        .gen_in(gen_a_r),
        .out_en(output_pin_enable_r[`BIT_CHAN_A]),
        .force_low(fault_output_action_r[`BIT_CHAN_A]),
        .fault(fault_cond),
        .invert(output_polarity_control_r[`BIT_CHAN_A]),
        .pin_r(channel_a_out)
    );

    pwm_out_stage u_stage_b (
        .clk(pclk),
        .rst_n(presetn),
        .gen_in(gen_b_r),
        .out_en(output_pin_enable_r[`BIT_CHAN_B]),
        .force_low(fault_output_action_r[`BIT_CHAN_B]),
        .fault(fault_cond),
        .invert(output_polarity_control_r[`BIT_CHAN_B]),
        .pin_r(channel_b_out)
    );

    // The line follows the masked word one cycle later.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_irq <= 1'b0;
        end else begin
            module_irq <= |masked_word;
        end
    end
endmodule // pwm_output_fault_and_gen_control
`default_nettype wire

// File: pwm_power_stage.sv
// Behavioural power stage that takes the two gate pins of the block.
`timescale 1ns/10ps
`default_nettype none
module pwm_power_stage (
    input wire logic gate_a,
    input wire logic gate_b,
    output logic leg_a,
    output logic leg_b
);
    // The stage follows its gates with no added delay, so that the pin
    // timing that the bench sees stays that of the block.
    assign leg_a = gate_a;
    assign leg_b = gate_b;
endmodule // pwm_power_stage
`default_nettype wire

// File: pwm_output_fault_and_gen_control_sva.sv
// Port-level checker of the output stage and its interrupt registers.
`timescale 1ns/10ps
`default_nettype none
module pwm_ofgc_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fault_in,
    input wire logic debug_in,
    input wire logic gen_irq_in,
    input wire logic channel_a_out,
    input wire logic channel_b_out,
    input wire logic module_irq
);
    logic [1:0] inten_r;
    logic [1:0] inv_r;
    logic [1:0] frc_r;
    logic done;
    // Mirrors of the control bits, updated only at accepted writes.
    assign done = psel && penable && pready && !pslverr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inten_r <= 2'h0;
            inv_r <= 2'h0;
            frc_r <= 2'h0;
        end else if (done && pwrite) begin
            if (paddr == 12'h014) inten_r <= {pwdata[16], pwdata[0]};
            if (paddr == 12'h00C) inv_r <= pwdata[1:0];
            if (paddr == 12'h010) frc_r <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !$past(penable);
    endsequence
    // Either fault source held long enough to clear its synchroniser.
    sequence s_fault_held;
        (fault_in || debug_in) [*4];
    endsequence
    a_ready_one_wait: assert property (s_take |=> pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    a_unmapped_err: assert property (pready && paddr == 12'h0FC |-> pslverr)
        else $error("unmapped access without error");
    a_inten_read: assert property (
        done && !pwrite && paddr == 12'h014
        |-> prdata == {15'h0, inten_r[1], 15'h0, inten_r[0]})
        else $error("interrupt enable read mismatch");
    a_raw_gen_live: assert property (
        done && !pwrite && paddr == 12'h018
        |-> prdata[0] == $past(gen_irq_in))
        else $error("raw generator bit not live");
    a_masked_gen: assert property (
        done && !pwrite && paddr == 12'h01C
        |-> prdata[0] == ($past(gen_irq_in) && inten_r[0]))
        else $error("masked generator bit mismatch");
    a_gen_irq_on: assert property (
        gen_irq_in && inten_r[0] |=> module_irq)
        else $error("enabled generator irq not passed");
    a_irq_quiet: assert property (
        inten_r == 2'h0 |=> !module_irq)
        else $error("module irq with all sources disabled");
    a_force_a_pin: assert property (
        s_fault_held ##0 $past(frc_r[0])
        |-> channel_a_out == $past(inv_r[0]))
        else $error("channel a not forced on fault");
    a_force_b_pin: assert property (
        s_fault_held ##0 $past(frc_r[1])
        |-> channel_b_out == $past(inv_r[1]))
        else $error("channel b not forced on fault");
endmodule // pwm_ofgc_sva
bind pwm_output_fault_and_gen_control pwm_ofgc_sva u_pwm_ofgc_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fault_in, .debug_in, .gen_irq_in, .channel_a_out,
    .channel_b_out, .module_irq);
`default_nettype wire

// File: tb_pwm_output_fault_and_gen_control.sv
// Self-checking bench of the output stage and generator zero control.
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_output_fault_and_gen_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_d, v, mx;
    logic pready, pslverr, rd_e, a_pin, b_pin, pin_a, pin_b, module_irq;
    logic fault_in = 0, debug_in = 0, gen_irq_in = 0;
    int err_total = 0, checks_done = 0;
    logic [11:0] amap [0:11] = '{12'h000, 12'h008, 12'h00C, 12'h010,
        12'h014, 12'h018, 12'h01C, 12'h020, 12'h040, 12'h050, 12'h054,
        12'h058};
    pwm_output_fault_and_gen_control u_pwm_output_fault_and_gen_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fault_in, .debug_in, .gen_irq_in,
        .channel_a_out(a_pin), .channel_b_out(b_pin), .module_irq);
    pwm_power_stage u_pwm_power_stage (.gate_a(a_pin), .gate_b(b_pin),
        .leg_a(pin_a), .leg_b(pin_b));
    always #5 pclk = ~pclk;
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t saw %h expected %h", $time, s, e);
        end
    endtask
    // The master waits for pready however long it takes; only the watchdog
    // ends a transfer that is never answered.
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1, d);
    endtask
    task rd(input logic [11:0] a);
        apb(a, 0, 32'h0);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Eight spaced reads of the counter; keeps the largest value seen.
    task sweep;
        mx = 0;
        repeat (8) begin
            rd(12'h054);
            if (rd_d > mx) mx = rd_d;
        end
    endtask
    task t_regs;
        foreach (amap[i]) begin
            rd(amap[i]);
            chk(rd_d, 32'h0);
        end
        wr(12'h0FC, 32'h1);
        chk(rd_e, 1'b1);
        wr(12'h018, 32'hFFFFFFFF);
        rd(12'h018);
        chk(rd_d, 32'h0);
        $display("test regs done");
    endtask
    task t_polarity;
        wr(12'h00C, 32'h3);
        cyc(3);
        chk({pin_a, pin_b}, 2'h3);
        wr(12'h00C, 32'h1);
        cyc(3);
        chk({pin_a, pin_b}, 2'h2);
        wr(12'h00C, 32'h0);
        $display("test polarity done");
    endtask
    task t_fault;
        wr(12'h058, 32'h0000FFFF);
        wr(12'h05C, 32'h0);
        wr(12'h050, 32'hA);
        wr(12'h008, 32'h3);
        wr(12'h040, 32'h1);
        cyc(30);
        chk({pin_a, pin_b}, 2'h2);
        wr(12'h010, 32'h3);
        fault_in <= 1;
        cyc(5);
        chk({pin_a, pin_b}, 2'h0);
        wr(12'h00C, 32'h3);
        cyc(3);
        chk({pin_a, pin_b}, 2'h3);
        fault_in <= 0;
        cyc(5);
        chk({pin_a, pin_b}, 2'h1);
        wr(12'h00C, 32'h2);
        wr(12'h008, 32'h1);
        wr(12'h010, 32'h2);
        debug_in <= 1;
        cyc(5);
        chk({pin_a, pin_b}, 2'h3);
        wr(12'h010, 32'h1);
        cyc(3);
        chk({pin_a, pin_b}, 2'h1);
        debug_in <= 0;
        wr(12'h010, 32'h0);
        wr(12'h00C, 32'h0);
        wr(12'h008, 32'h3);
        $display("test fault done");
    endtask
    task t_irq;
        fault_in <= 1;
        cyc(4);
        rd(12'h020);
        chk(rd_d, 32'h1);
        fault_in <= 0;
        cyc(4);
        rd(12'h020);
        chk(rd_d, 32'h0);
        rd(12'h018);
        chk(rd_d, 32'h00010000);
        rd(12'h01C);
        chk(rd_d, 32'h0);
        chk(module_irq, 1'b0);
        wr(12'h014, 32'h00010000);
        cyc(2);
        rd(12'h01C);
        chk(rd_d, 32'h00010000);
        chk(module_irq, 1'b1);
        wr(12'h01C, 32'h0);
        rd(12'h018);
        chk(rd_d, 32'h00010000);
        wr(12'h01C, 32'h00010000);
        rd(12'h018);
        chk(rd_d, 32'h0);
        cyc(2);
        chk(module_irq, 1'b0);
        gen_irq_in <= 1;
        wr(12'h014, 32'h0);
        cyc(2);
        rd(12'h018);
        chk(rd_d, 32'h1);
        chk(module_irq, 1'b0);
        wr(12'h014, 32'h1);
        cyc(2);
        chk(module_irq, 1'b1);
        wr(12'h01C, 32'h1);
        rd(12'h01C);
        chk(rd_d, 32'h1);
        gen_irq_in <= 0;
        cyc(2);
        rd(12'h018);
        chk(rd_d, 32'h0);
        chk(module_irq, 1'b0);
        wr(12'h014, 32'h0);
        $display("test irq done");
    endtask
    task t_count;
        wr(12'h040, 32'h0);
        rd(12'h054);
        v = rd_d;
        cyc(5);
        rd(12'h054);
        chk(rd_d, v);
        wr(12'h050, 32'd40);
        wr(12'h040, 32'h1);
        cyc(50);
        sweep;
        chk(mx > 10 && mx <= 40, 1'b1);
        // Load in synchronous mode must wait for the request.
        wr(12'h040, 32'h9);
        wr(12'h050, 32'h3);
        cyc(50);
        sweep;
        chk(mx > 3, 1'b1);
        wr(12'h000, 32'h1);
        cyc(50);
        rd(12'h000);
        chk(rd_d, 32'h0);
        sweep;
        chk(mx <= 3, 1'b1);
        wr(12'h040, 32'h1);
        wr(12'h050, 32'd20);
        cyc(50);
        sweep;
        chk(mx > 3 && mx <= 20, 1'b1);
        wr(12'h040, 32'h3);
        cyc(50);
        sweep;
        chk(mx > 0 && mx <= 20, 1'b1);
        debug_in <= 1;
        cyc(50);
        rd(12'h054);
        chk(rd_d, 32'h0);
        wr(12'h040, 32'h7);
        sweep;
        chk(mx > 0, 1'b1);
        debug_in <= 0;
        // Both comparators in synchronous mode hold their old values.
        wr(12'h040, 32'h31);
        wr(12'h058, 32'h0);
        wr(12'h05C, 32'h0000FFFF);
        cyc(50);
        chk(pin_a, 1'b1);
        chk(pin_b, 1'b0);
        wr(12'h000, 32'h1);
        cyc(50);
        chk(pin_a, 1'b0);
        chk(pin_b, 1'b1);
        $display("test count done");
    endtask
    initial begin
        #100000;
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test;
    end
    initial begin
        cyc(2);
        presetn <= 1;
        t_regs;
        t_polarity;
        t_fault;
        t_irq;
        t_count;
        end_of_test;
    end
endmodule // tb_pwm_output_fault_and_gen_control
`default_nettype wire
